// ### rtl/cisa_exec_consts.svh
// Constants for the compact instruction store and ALU execute block
// Operation
// - Decode three-register subtract and its fields
// - Subtract modulo 32 bits into destination
// - Subtract never raises any exception
// - Short store: offset<<2 plus base register
// - Extended store: sign-extended 16-bit unscaled offset
// - Misaligned store raises address error, no write
// - Stack store: 8-bit offset<<2 plus register 29
// - Extended stack store needs zero sub-field
// - Return-address store: register 31 at stack
// - Extended return-address store: unscaled 16-bit offset
// - Translate as data store, write full word
// - Exclusive OR into first register
// - Zero-extend byte of first register
// - Zero-extend halfword of first register
// - Variable logical right shift, zero fill
`ifndef CISA_EXEC_CONSTS_SVH
`define CISA_EXEC_CONSTS_SVH

// Major opcodes, bits 15:11
`define THREE_REG_MAJOR      5'h1C
`define TWO_REG_MAJOR        5'h1D
`define STORE_WORD_OP        5'h1B
`define STACK_STORE_MAJOR    5'h1A
`define IMM8_MAJOR           5'h0C
// Minor codes
`define SUBTRACT_WORD_OP     2'h3
`define VAR_LOGICAL_SHIFT_OP 5'h06
`define XOR_FUNCTION         5'h0E
`define CONVERT_FUNCTION     5'h11
`define ZERO_EXT_BYTE_OP     3'h0
`define ZERO_EXT_HALF_OP     3'h1
`define RETURN_ADDR_STACK_STORE 3'h2
`define EXT_ZERO_SUBFIELD    3'h0
// Fixed registers
`define STACK_POINTER_REG    5'h1D
`define RETURN_ADDRESS_REG   5'h1F
`define REG_CODE0_TARGET     5'h10
`define REG_CODE1_TARGET     5'h11
// Full-word byte enables and reset values
`define WORD_BYTE_EN         4'hF
`define RESET_WORD           32'h0000_0000

`endif

// ### rtl/cisa_exec_pkg.sv
// Types shared by the compact instruction execute block
package cisa_exec_pkg;

  // Instruction as delivered by fetch, with optional prefix
  typedef struct packed {
    logic        ext;
    logic [10:0] ext_imm;
    logic [15:0] op;
  } instr_t;

  // Completed word write toward the load/store unit
  typedef struct packed {
    logic [31:0] paddr;
    logic [31:0] data;
    logic [2:0]  cache_attribute;
    logic [3:0]  be;
  } mem_wr_t;

  // Register writeback report
  typedef struct packed {
    logic [4:0]  idx;
    logic [31:0] data;
  } wb_t;

  typedef enum logic [3:0] {
    OP_SUB, OP_VAR_LOGICAL_SHIFT_OP, OP_XOR, OP_ZEB, OP_ZEH,
    OP_SW, OP_STACK_STORE_MAJOR, OP_SWRA, OP_UNSUP
  } op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_XLAT, ST_WRITE} st_t;

endpackage

// ### rtl/cisa_exec.sv
// Decode and execute for subtract, shift, xor, zero-extend and word stores
`timescale 1ns/1ps
`include "cisa_exec_consts.svh"

module cisa_exec
  import cisa_exec_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Instruction from fetch
  input  wire logic        instr_valid,
  input  wire instr_t      instr,
  output logic             instr_ready_q,
  // Register preload port
  input  wire logic        dbg_we,
  input  wire logic [4:0]  dbg_idx,
  input  wire logic [31:0] dbg_wdata,
  // Address translation
  output logic             xlat_valid_q,
  output logic [31:0]      xlat_vaddr_q,
  input  wire logic        xlat_ack,
  input  wire logic [31:0] xlat_paddr,
  input  wire logic [2:0]  xlat_cca,
  // Memory word write
  output logic             wr_valid_q,
  output mem_wr_t          wr_q,
  input  wire logic        wr_ack,
  // Results and exceptions
  output logic             wb_valid_q,
  output wb_t              wb_q,
  output logic             addr_err_q,
  output logic [31:0]      bad_vaddr_q,
  output logic             unsup_q
);

  // Register code translation
  // fixed code map
  function automatic logic [4:0] xl(input logic [2:0] c);
    if (c == 3'h0) begin
      return `REG_CODE0_TARGET;
    end else if (c == 3'h1) begin
      return `REG_CODE1_TARGET;
    end
    return {2'b00, c};
  endfunction

  logic [31:0] regs [32];
  st_t         st_q;
  op_t         op_c;
  logic [15:0] iw;
  logic        acc;
  logic        is_st;
  logic [31:0] ra_c;
  logic [31:0] rb_c;
  logic [31:0] res_c;
  logic [4:0]  dst_c;
  logic [31:0] off_c;
  logic [31:0] base_c;
  logic [31:0] va_c;
  logic [31:0] sd_c;
  logic [31:0] sdata_q;
  logic [15:0] eoff;

  assign iw    = instr.op;
  assign acc   = instr_valid && instr_ready_q;
  assign is_st = (op_c == OP_SW) || (op_c == OP_STACK_STORE_MAJOR) || (op_c == OP_SWRA);
  // Prefix carries offset 10:5 then 15:11
  assign eoff  = {instr.ext_imm[4:0], instr.ext_imm[10:5], iw[4:0]};
  assign ra_c  = regs[xl(iw[10:8])];
  assign rb_c  = regs[xl(iw[7:5])];

  // Decode; prefixed forms of non-extensible ops are unsupported
  always_comb begin
    op_c = OP_UNSUP;
    unique case (iw[15:11])
      `THREE_REG_MAJOR: begin
        if (iw[1:0] == `SUBTRACT_WORD_OP) begin
          op_c = OP_SUB;
        end
      end
      `TWO_REG_MAJOR: begin
        if (iw[4:0] == `VAR_LOGICAL_SHIFT_OP) begin
          op_c = OP_VAR_LOGICAL_SHIFT_OP;
        end else if (iw[4:0] == `XOR_FUNCTION) begin
          op_c = OP_XOR;
        end else if (iw[4:0] == `CONVERT_FUNCTION && iw[7:5] == `ZERO_EXT_BYTE_OP) begin
          op_c = OP_ZEB;
        end else if (iw[4:0] == `CONVERT_FUNCTION && iw[7:5] == `ZERO_EXT_HALF_OP) begin
          op_c = OP_ZEH;
        end
      end
      `STORE_WORD_OP: op_c = OP_SW;
      `STACK_STORE_MAJOR: begin
        if (!instr.ext || iw[7:5] == `EXT_ZERO_SUBFIELD) begin
          op_c = OP_STACK_STORE_MAJOR;
        end
      end
      `IMM8_MAJOR: begin
        if (iw[10:8] == `RETURN_ADDR_STACK_STORE &&
            (!instr.ext || iw[7:5] == `EXT_ZERO_SUBFIELD)) begin
          op_c = OP_SWRA;
        end
      end
      default: op_c = OP_UNSUP;
    endcase
    if (instr.ext && op_c != OP_SW && op_c != OP_STACK_STORE_MAJOR && op_c != OP_SWRA) begin // Not is_st: avoids a loop
      op_c = OP_UNSUP;
    end
  end

  // ALU result and destination
  always_comb begin
    res_c = `RESET_WORD;
    dst_c = xl(iw[10:8]);
    unique case (op_c)
      OP_SUB: begin
        res_c = 32'(ra_c - rb_c);
        dst_c = xl(iw[4:2]);
      end
      OP_VAR_LOGICAL_SHIFT_OP: begin
        res_c = rb_c >> ra_c[4:0];
        dst_c = xl(iw[7:5]);
      end
      OP_XOR: res_c = ra_c ^ rb_c;
      OP_ZEB: res_c = {24'h00_0000, ra_c[7:0]};
      OP_ZEH: res_c = {16'h0000, ra_c[15:0]};
      default: res_c = `RESET_WORD;
    endcase
  end

  // Store address: scaled zero-extended or unscaled sign-extended offset
  always_comb begin
    off_c  = {{16{eoff[15]}}, eoff};
    base_c = regs[`STACK_POINTER_REG];
    sd_c   = ra_c;
    unique case (op_c)
      OP_SW: begin
        base_c = ra_c;
        sd_c   = rb_c;
        if (!instr.ext) begin
          off_c = {25'h000_0000, iw[4:0], 2'b00};
        end
      end
      OP_STACK_STORE_MAJOR, OP_SWRA: begin
        if (!instr.ext) begin
          off_c = {22'h00_0000, iw[7:0], 2'b00};
        end
        if (op_c == OP_SWRA) begin
          sd_c = regs[`RETURN_ADDRESS_REG];
        end
      end
      default: off_c = {{16{eoff[15]}}, eoff};
    endcase
    va_c = 32'(base_c + off_c);
  end

  // Register file; register zero is never written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= `RESET_WORD;
      end
    end else if (acc && !is_st && op_c != OP_UNSUP) begin
      regs[dst_c] <= res_c;
    end else if (dbg_we && dbg_idx != 5'h00) begin
      regs[dbg_idx] <= dbg_wdata;
    end
  end

  // Writeback report and exception flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid_q  <= 1'b0;
      wb_q        <= '0;
      addr_err_q  <= 1'b0;
      bad_vaddr_q <= `RESET_WORD;
      unsup_q     <= 1'b0;
    end else begin
      wb_valid_q <= acc && !is_st && op_c != OP_UNSUP;
      unsup_q    <= acc && op_c == OP_UNSUP;
      addr_err_q <= acc && is_st && va_c[1:0] != 2'b00;
      if (acc && !is_st) begin
        wb_q <= '{idx: dst_c, data: res_c};
      end
      if (acc && is_st && va_c[1:0] != 2'b00) begin
        bad_vaddr_q <= va_c;
      end
    end
  end

  // Store sequence: translate, then one full-word write
  // data store then word write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= ST_IDLE;
      instr_ready_q <= 1'b0;
      xlat_valid_q  <= 1'b0;
      xlat_vaddr_q  <= `RESET_WORD;
      sdata_q       <= `RESET_WORD;
      wr_valid_q    <= 1'b0;
      wr_q          <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          instr_ready_q <= 1'b1;
          if (acc && is_st && va_c[1:0] == 2'b00) begin
            st_q          <= ST_XLAT;
            instr_ready_q <= 1'b0;
            xlat_valid_q  <= 1'b1;
            xlat_vaddr_q  <= va_c;
            sdata_q       <= sd_c;
          end
        end
        ST_XLAT: begin
          if (xlat_ack) begin
            st_q         <= ST_WRITE;
            xlat_valid_q <= 1'b0;
            wr_valid_q   <= 1'b1;
            wr_q         <= '{paddr: xlat_paddr, data: sdata_q,
                              cache_attribute: xlat_cca, be: `WORD_BYTE_EN};
          end
        end
        ST_WRITE: begin
          // Ready returns one cycle after the ack, keeping it registered
          if (wr_ack) begin
            st_q       <= ST_IDLE;
            wr_valid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_sub;
    acc && op_c == OP_SUB |=> wb_valid_q && wb_q.data == $past(ra_c) - $past(rb_c);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");

  property p_sub_noexc;
    acc && op_c == OP_SUB |=> wb_valid_q && !addr_err_q && !unsup_q;
  endproperty
  a_sub_noexc: assert property (p_sub_noexc) else $error("subtract raised exception");

  property p_srl;
    acc && op_c == OP_VAR_LOGICAL_SHIFT_OP |=> wb_q.data == ($past(rb_c) >> $past(ra_c[4:0]))
      && wb_q.idx == xl($past(iw[7:5]));
  endproperty
  a_srl: assert property (p_srl) else $error("shift result wrong");

  property p_xor;
    acc && op_c == OP_XOR |=> wb_q.data == ($past(ra_c) ^ $past(rb_c));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_zext;
    acc && (op_c == OP_ZEB || op_c == OP_ZEH) |=>
      (wb_q.data[31:16] == 16'h0000) && ($past(op_c) == OP_ZEH || wb_q.data[15:8] == 8'h00);
  endproperty
  a_zext: assert property (p_zext) else $error("zero extend left high bits");

  property p_misalign;
    acc && is_st && va_c[1:0] != 2'b00 |=> addr_err_q && !xlat_valid_q ##1 !wr_valid_q;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned store not trapped");

  property p_stack_store_major_addr;
    acc && op_c == OP_STACK_STORE_MAJOR && !instr.ext && va_c[1:0] == 2'b00 |=>
      xlat_vaddr_q == $past(regs[`STACK_POINTER_REG]) + {22'h00_0000, $past(iw[7:0]), 2'b00};
  endproperty
  a_stack_store_major_addr: assert property (p_stack_store_major_addr) else $error("stack store address wrong");

  property p_ext_addr;
    acc && op_c == OP_SW && instr.ext && va_c[1:0] == 2'b00 |=>
      xlat_vaddr_q == $past(ra_c) + {{16{$past(eoff[15])}}, $past(eoff)};
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("extended store address wrong");

  property p_word_write;
    xlat_valid_q && xlat_ack |=> wr_valid_q && wr_q.be == `WORD_BYTE_EN
      && wr_q.cache_attribute == $past(xlat_cca) && wr_q.paddr == $past(xlat_paddr);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write malformed");

  c_sub: cover property (acc && op_c == OP_SUB);
  c_store: cover property (wr_valid_q && wr_ack);
  c_misalign: cover property (addr_err_q);
  c_swra_ext: cover property (acc && op_c == OP_SWRA && instr.ext);

endmodule

// ### tb/lsu_model.sv
// Load/store unit model: data-store translation and word-write acceptance
`timescale 1ns/1ps

module lsu_model
  import cisa_exec_pkg::*;
(
  // Clock and pacing
  input  wire logic        ref_clk,
  input  wire logic [3:0]  lat,
  // Translation side
  input  wire logic        xlat_valid_q,
  input  wire logic [31:0] xlat_vaddr_q,
  output logic             xlat_ack,
  output logic [31:0]      xlat_paddr,
  output logic [2:0]       xlat_cca,
  // Write side
  input  wire logic        wr_valid_q,
  input  wire mem_wr_t     wr_q,
  output logic             wr_ack,
  output mem_wr_t          got
);
  // Page remap so a virtual address leaking through is caught
  localparam logic [31:0] PAGE_XOR = 32'h4000_0000;
  localparam logic [2:0]  CCA_VAL  = 3'h3;

  initial begin
    xlat_ack   = 1'b0;
    xlat_paddr = 32'h0000_0000;
    xlat_cca   = 3'h0;
    forever begin
      @(posedge ref_clk);
      #1;
      if (xlat_valid_q === 1'b1) begin
        repeat (lat) begin
          @(posedge ref_clk);
          #1;
        end
        xlat_ack   = 1'b1;
        xlat_paddr = xlat_vaddr_q ^ PAGE_XOR;
        xlat_cca   = CCA_VAL;
        @(posedge ref_clk);
        #1;
        // Stale answer lines are scrambled, not held
        xlat_ack   = 1'b0;
        xlat_paddr = ~xlat_paddr;
        xlat_cca   = ~xlat_cca;
      end
    end
  end

  initial begin
    wr_ack = 1'b0;
    got    = '0;
    forever begin
      @(posedge ref_clk);
      #1;
      if (wr_valid_q === 1'b1) begin
        repeat (lat) begin
          @(posedge ref_clk);
          #1;
        end
        wr_ack = 1'b1;
        got    = wr_q;
        @(posedge ref_clk);
        #1;
        wr_ack = 1'b0;
      end
    end
  end
endmodule

// ### tb/compact_isa_store_alu_exec_test.sv
// Self-checking bench for the compact instruction execute block
`timescale 1ns/1ps
`include "cisa_exec_consts.svh"

module compact_isa_store_alu_exec_test
  import cisa_exec_pkg::*;
;
  logic        ref_clk, rst_n, instr_valid, instr_ready_q, dbg_we;
  logic        xlat_valid_q, xlat_ack, wr_valid_q, wr_ack, wb_valid_q, addr_err_q, unsup_q;
  instr_t      instr;
  logic [4:0]  dbg_idx;
  logic [31:0] dbg_wdata, xlat_vaddr_q, xlat_paddr, bad_vaddr_q;
  logic [2:0]  xlat_cca;
  logic [3:0]  lat;
  mem_wr_t     wr_q, got;
  wb_t         wb_q;
  int          n_fail, compares;

  cisa_exec cisa_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready_q(instr_ready_q), .dbg_we(dbg_we), .dbg_idx(dbg_idx), .dbg_wdata(dbg_wdata),
    .xlat_valid_q(xlat_valid_q), .xlat_vaddr_q(xlat_vaddr_q), .xlat_ack(xlat_ack), .xlat_paddr(xlat_paddr),
    .xlat_cca(xlat_cca), .wr_valid_q(wr_valid_q), .wr_q(wr_q), .wr_ack(wr_ack), .wb_valid_q(wb_valid_q),
    .wb_q(wb_q), .addr_err_q(addr_err_q), .bad_vaddr_q(bad_vaddr_q), .unsup_q(unsup_q));

  lsu_model lsu_model_inst (.ref_clk(ref_clk), .lat(lat), .xlat_valid_q(xlat_valid_q),
    .xlat_vaddr_q(xlat_vaddr_q), .xlat_ack(xlat_ack), .xlat_paddr(xlat_paddr), .xlat_cca(xlat_cca),
    .wr_valid_q(wr_valid_q), .wr_q(wr_q), .wr_ack(wr_ack), .got(got));

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  // Offset scatter: prefix carries bits 10:5 then 15:11, low five ride in the opcode
  function automatic instr_t mk(input logic ext, input logic [15:0] off, input logic [15:0] op);
    return {ext, off[10:5], off[15:11], op[15:5], ext ? off[4:0] : op[4:0]};
  endfunction

  // Leaves the write strobe up so preloads run back to back
  task automatic set_reg(input logic [4:0] idx, input logic [31:0] val);
    dbg_we    = 1'b1;
    dbg_idx   = idx;
    dbg_wdata = val;
    @(posedge ref_clk);
    #1;
  endtask

  // Offer one instruction and return just after the edge that takes it
  task automatic issue(input instr_t i);
    int k;
    k           = 0;
    instr       = i;
    instr_valid = 1'b1;
    while (instr_ready_q !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("ready", 32'h1, {31'h0, instr_ready_q});
    @(posedge ref_clk);
    #1;
  endtask

  task automatic alu(input instr_t i, input logic [4:0] idx, input logic [31:0] exp);
    issue(i);
    chk("wb_valid", 32'h1, {31'h0, wb_valid_q});
    chk("wb_idx", {27'h0, idx}, {27'h0, wb_q.idx});
    chk("wb_data", exp, wb_q.data);
    chk("no_exc", 32'h0, {30'h0, addr_err_q, unsup_q});
  endtask

  task automatic store(input instr_t i, input logic [31:0] va, input logic [31:0] data);
    int k;
    issue(i);
    instr_valid = 1'b0;
    chk("no_exc", 32'h0, {30'h0, addr_err_q, unsup_q});
    k = 0;
    while (wr_valid_q !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while ((instr_ready_q !== 1'b1 || wr_valid_q !== 1'b0) && k < 80) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("store_done", 32'h1, {31'h0, wr_valid_q === 1'b0 && instr_ready_q === 1'b1});
    chk("paddr", va ^ 32'h4000_0000, got.paddr);
    chk("data", data, got.data);
    chk("cca", 32'h3, {29'h0, got.cache_attribute});
    chk("be", {28'h0, `WORD_BYTE_EN}, {28'h0, got.be});
  endtask

  task automatic fault(input instr_t i, input logic [1:0] flags, input logic [31:0] va);
    issue(i);
    chk("flags", {30'h0, flags}, {30'h0, addr_err_q, unsup_q});
    chk("no_xlat", 32'h0, {31'h0, xlat_valid_q});
    if (flags == 2'h2) begin
      chk("bad_vaddr", va, bad_vaddr_q);
    end
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0; instr_valid = 1'b0; instr = '0; dbg_we = 1'b0; dbg_idx = '0; dbg_wdata = '0;
    lat = 4'h0; n_fail = 0; compares = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk("reset_outs", 32'h0, {26'h0, instr_ready_q, xlat_valid_q, wr_valid_q, wb_valid_q, addr_err_q, unsup_q});
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    set_reg(5'h10, 32'h0000_0005); set_reg(5'h11, 32'h0000_0027); set_reg(5'h02, 32'h8000_00F4);
    set_reg(5'h03, 32'h1234_5678); set_reg(5'h05, 32'h2000_0000); set_reg(5'h06, 32'hA5A5_0F0F);
    set_reg(5'h07, 32'h0707_0707); set_reg(5'h1D, 32'h0000_1000); set_reg(5'h1F, 32'hC0DE_0001);
    dbg_we = 1'b0;
    alu({1'b0, 11'h000, `THREE_REG_MAJOR, 3'h0, 3'h1, 3'h4, `SUBTRACT_WORD_OP}, 5'h04, 32'hFFFF_FFDE);
    alu({1'b0, 11'h000, `TWO_REG_MAJOR, 3'h1, 3'h3, `VAR_LOGICAL_SHIFT_OP}, 5'h03, 32'h1234_5678 >> 5'h07);
    alu({1'b0, 11'h000, `TWO_REG_MAJOR, 3'h2, 3'h4, `XOR_FUNCTION}, 5'h02, 32'h7FFF_FF2A);
    alu({1'b0, 11'h000, `TWO_REG_MAJOR, 3'h2, `ZERO_EXT_BYTE_OP, `CONVERT_FUNCTION}, 5'h02, 32'h0000_002A);
    alu({1'b0, 11'h000, `TWO_REG_MAJOR, 3'h4, `ZERO_EXT_HALF_OP, `CONVERT_FUNCTION}, 5'h04, 32'h0000_FFDE);
    store(mk(1'b0, 16'h0000, {`STORE_WORD_OP, 3'h5, 3'h6, 5'h1F}), 32'h2000_007C, 32'hA5A5_0F0F);
    store(mk(1'b1, 16'hFFF8, {`STORE_WORD_OP, 3'h5, 3'h6, 5'h00}), 32'h1FFF_FFF8, 32'hA5A5_0F0F);
    lat = 4'h3;
    store(mk(1'b0, 16'h0000, {`STACK_STORE_MAJOR, 3'h7, 8'hFF}), 32'h0000_13FC, 32'h0707_0707);
    store(mk(1'b1, 16'h8004, {`STACK_STORE_MAJOR, 3'h7, 8'h00}), 32'hFFFF_9004, 32'h0707_0707);
    store(mk(1'b0, 16'h0000, {`IMM8_MAJOR, `RETURN_ADDR_STACK_STORE, 8'h01}), 32'h0000_1004, 32'hC0DE_0001);
    store(mk(1'b1, 16'h0010, {`IMM8_MAJOR, `RETURN_ADDR_STACK_STORE, 8'h00}), 32'h0000_1010, 32'hC0DE_0001);
    // Faults back to back; none may reach translation
    fault(mk(1'b1, 16'h0002, {`STORE_WORD_OP, 3'h5, 3'h6, 5'h00}), 2'h2, 32'h2000_0002);
    fault(mk(1'b0, 16'h0000, {`STORE_WORD_OP, 3'h2, 3'h6, 5'h00}), 2'h2, 32'h0000_002A);
    fault(mk(1'b1, 16'h0001, {`IMM8_MAJOR, `RETURN_ADDR_STACK_STORE, 8'h00}), 2'h2, 32'h0000_1001);
    fault(mk(1'b1, 16'h0000, {`STACK_STORE_MAJOR, 3'h7, 3'h1, 5'h00}), 2'h1, 32'h0000_0000);
    // Prefixed xor is refused and must leave its register alone
    fault(mk(1'b1, 16'h000E, {`TWO_REG_MAJOR, 3'h2, 3'h4, `XOR_FUNCTION}), 2'h1, 32'h0000_0000);
    fault({1'b0, 11'h000, 16'h0000}, 2'h1, 32'h0000_0000);
    alu({1'b0, 11'h000, `TWO_REG_MAJOR, 3'h2, `ZERO_EXT_BYTE_OP, `CONVERT_FUNCTION}, 5'h02, 32'h0000_002A);
    instr_valid = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("no_write", 32'h0000_1010 ^ 32'h4000_0000, got.paddr);
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end
endmodule
